// ==== psm_pkg.sv ====
// Package for the PHY status mirror block: register indices, byte addresses,
// field positions, reset values and timing figures.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package psm_pkg;

    // ------------------------------------------------------------------
    // Register indices and byte addresses
    // ------------------------------------------------------------------
    // Printed offsets are register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_BASIC_MODE_STATUS = 8'h01;
    localparam logic [7:0] IDX_AUTONEG_EXPANSION = 8'h06;
    localparam logic [7:0] IDX_PHY_STATUS_SUMMARY = 8'h10;
    localparam logic [7:0] IDX_INTERRUPT_SOURCE_STATUS = 8'h12;
    localparam logic [7:0] IDX_INTERRUPT_MASK = 8'h13;
    localparam logic [7:0] IDX_FALSE_CARRIER_COUNTER = 8'h14;
    localparam logic [7:0] IDX_TENBASE_T_STATUS_CONTROL = 8'h1A;
    localparam int ADDR_W = 8;
    localparam logic [9:0] ADDR_BASIC_MODE_STATUS = {IDX_BASIC_MODE_STATUS, 2'b00};
    localparam logic [9:0] ADDR_AUTONEG_EXPANSION = {IDX_AUTONEG_EXPANSION, 2'b00};
    localparam logic [9:0] ADDR_PHY_STATUS_SUMMARY = {IDX_PHY_STATUS_SUMMARY, 2'b00};
    localparam logic [9:0] ADDR_INTERRUPT_SOURCE_STATUS = {IDX_INTERRUPT_SOURCE_STATUS, 2'b00};
    localparam logic [9:0] ADDR_INTERRUPT_MASK = {IDX_INTERRUPT_MASK, 2'b00};
    localparam logic [9:0] ADDR_FALSE_CARRIER_COUNTER = {IDX_FALSE_CARRIER_COUNTER, 2'b00};
    localparam logic [9:0] ADDR_TENBASE_T_STATUS_CONTROL = {IDX_TENBASE_T_STATUS_CONTROL, 2'b00};

    // ------------------------------------------------------------------
    // Summary register field positions
    // ------------------------------------------------------------------
    localparam int SUM_POLARITY = 12;
    localparam int SUM_FALSE_CARRIER = 11;
    localparam int SUM_SIGNAL_DETECT = 10;
    localparam int SUM_DESCRAMBLER_LOCK = 9;
    localparam int SUM_PAGE_RECEIVED = 8;
    localparam int SUM_INTERRUPT_PENDING = 7;
    localparam int SUM_REMOTE_FAULT = 6;
    localparam int SUM_JABBER = 5;

    // Field positions in the source register views.
    localparam int TENBT_POLARITY = 4;
    localparam int ANEG_PAGE_RECEIVED = 1;
    localparam int BMS_REMOTE_FAULT = 4;
    localparam int BMS_JABBER = 1;

    // ------------------------------------------------------------------
    // Input pin order and event bit order
    // ------------------------------------------------------------------
    localparam int NUM_IN = 7;
    localparam int IN_POLARITY = 0;
    localparam int IN_FALSE_CARRIER = 1;
    localparam int IN_SIGNAL_DETECT = 2;
    localparam int IN_DESCRAMBLER_LOCK = 3;
    localparam int IN_PAGE_RECEIVED = 4;
    localparam int IN_REMOTE_FAULT = 5;
    localparam int IN_JABBER = 6;

    // ------------------------------------------------------------------
    // Reset values and bus answers
    // ------------------------------------------------------------------
    localparam logic [15:0] SUMMARY_RESET = 16'h0000;
    localparam logic [NUM_IN-1:0] EVENT_RESET = 7'h00;
    localparam logic [NUM_IN-1:0] MASK_RESET = 7'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    localparam int CLK_PERIOD_NS = 10;

endpackage : psm_pkg

// ==== psm_sync.sv ====
// Three-stage input synchroniser with an agreement filter, one lane per bit.
// Assumes inputs arrive asynchronously to aclk; output changes only when
// the second and third stages agree.
`timescale 1ns/1ps

module psm_sync #(
    parameter int WIDTH = 7
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);

    // ------------------------------------------------------------------
    // Per-bit synchroniser lanes
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_lane
            logic stage1;
            logic stage2;
            logic stage3;
            // Stage one feeds only stage two, so metastability cannot reach logic.
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    stage1 <= 1'b0;
                    stage2 <= 1'b0;
                    stage3 <= 1'b0;
                    stable_out[gi] <= 1'b0;
                end else if (ce) begin
                    stage1 <= async_in[gi];
                    stage2 <= stage1;
                    stage3 <= stage2;
                    if (stage2 == stage3) begin
                        stable_out[gi] <= stage3;
                    end
                end
            end
        end
    endgenerate

endmodule : psm_sync

// ==== psm_status_mirror.sv ====
// PHY status summary mirror bits 12 down to 5 with their clear-on-read
// links to the source registers, an AXI4-Lite slave and an interrupt.
// Assumes status condition pins are asynchronous to aclk and one 100 MHz clock.
`timescale 1ns/1ps

// Functional notes
// - Bit 12 mirrors ten-base-T polarity bit 4.
// - Polarity clears on ten-base-T read only.
// - Polarity reads 1 when inverted, 0 correct.
// - Bit 11 latches false carrier until counter read.
// - False carrier clears on counter read only.
// - Bit 10 is latch-low signal detect.
// - Bit 9 is latch-low descrambler lock.
// - Bit 8 duplicates expansion page-received bit 1.
// - Page bit clears on expansion read only.
// - Bit 7 pending interrupt, cleared reading source status.
// - Bit 6 reports partner remote fault.
// - Remote fault clears on basic status read, reset.
// - Bit 5 jabber, meaningful only at 10 Mb/s.
// - Jabber duplicates basic status jabber bit.
// - Latch-high bits set per event, hold until read.
module psm_status_mirror (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic polarity_inverted,
    input wire logic false_carrier,
    input wire logic signal_detect,
    input wire logic descrambler_lock,
    input wire logic page_received,
    input wire logic remote_fault,
    input wire logic jabber,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq
);

    localparam int N = psm_pkg::NUM_IN;

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    logic [N-1:0] raw_in;
    logic [N-1:0] live;
    logic [N-1:0] live_prev;
    logic [N-1:0] rise;
    logic [N-1:0] fall;

    assign raw_in = {jabber, remote_fault, page_received, descrambler_lock,
                     signal_detect, false_carrier, polarity_inverted};

    psm_sync #(
        .WIDTH(N)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .async_in(raw_in),
        .stable_out(live)
    );

    // Edge history for the interrupt events.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            live_prev <= psm_pkg::EVENT_RESET;
        end else if (ce) begin
            live_prev <= live;
        end
    end

    assign rise = live & ~live_prev;
    assign fall = ~live & live_prev;

    // ------------------------------------------------------------------
    // Read channel decode
    // ------------------------------------------------------------------
    logic rd_fire;
    logic sel_summary;
    logic sel_tenbt;
    logic sel_fc_counter;
    logic sel_aneg;
    logic sel_int_status;
    logic sel_int_mask;
    logic sel_basic;
    logic rd_mapped;
    logic rvalid_q, bvalid_q;

    assign s_axi_arready = !rvalid_q && ce;
    assign s_axi_rvalid = rvalid_q && ce;    // A frozen block shows no handshake at all.
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign sel_summary = s_axi_araddr == psm_pkg::ADDR_PHY_STATUS_SUMMARY;
    assign sel_tenbt = s_axi_araddr == psm_pkg::ADDR_TENBASE_T_STATUS_CONTROL;
    assign sel_fc_counter = s_axi_araddr == psm_pkg::ADDR_FALSE_CARRIER_COUNTER;
    assign sel_aneg = s_axi_araddr == psm_pkg::ADDR_AUTONEG_EXPANSION;
    assign sel_int_status = s_axi_araddr == psm_pkg::ADDR_INTERRUPT_SOURCE_STATUS;
    assign sel_int_mask = s_axi_araddr == psm_pkg::ADDR_INTERRUPT_MASK;
    assign sel_basic = s_axi_araddr == psm_pkg::ADDR_BASIC_MODE_STATUS;
    assign rd_mapped = sel_summary | sel_tenbt | sel_fc_counter | sel_aneg | sel_int_status | sel_int_mask | sel_basic;

    // ------------------------------------------------------------------
    // Latch-high and latch-low status bits
    // ------------------------------------------------------------------
    logic pol_latch;
    logic fc_latch;
    logic page_latch;
    logic rf_latch;
    logic jab_latch;
    logic sd_latch;
    logic lock_latch;
    logic next_pol_latch;
    logic next_fc_latch;
    logic next_page_latch;
    logic next_rf_latch;
    logic next_jab_latch;
    logic next_sd_latch;
    logic next_lock_latch;

    // A set in the same cycle as the clearing read wins, so no event is lost.
    assign next_pol_latch = live[psm_pkg::IN_POLARITY]
                            | (pol_latch & !(rd_fire & sel_tenbt));
    assign next_fc_latch = live[psm_pkg::IN_FALSE_CARRIER]
                           | (fc_latch & !(rd_fire & sel_fc_counter));
    assign next_page_latch = live[psm_pkg::IN_PAGE_RECEIVED]
                             | (page_latch & !(rd_fire & sel_aneg));
    assign next_rf_latch = live[psm_pkg::IN_REMOTE_FAULT]
                           | (rf_latch & !(rd_fire & sel_basic));
    assign next_jab_latch = live[psm_pkg::IN_JABBER]
                            | (jab_latch & !(rd_fire & sel_basic));
    // Latch-low bits keep a drop until the summary read, then follow the pin.
    assign next_sd_latch = live[psm_pkg::IN_SIGNAL_DETECT]
                           & (sd_latch | (rd_fire & sel_summary));
    assign next_lock_latch = live[psm_pkg::IN_DESCRAMBLER_LOCK]
                             & (lock_latch | (rd_fire & sel_summary));

    // All mirror latches start cleared.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pol_latch <= 1'b0;
            fc_latch <= 1'b0;
            page_latch <= 1'b0;
            rf_latch <= 1'b0;
            jab_latch <= 1'b0;
            sd_latch <= 1'b0;
            lock_latch <= 1'b0;
        end else if (ce) begin
            pol_latch <= next_pol_latch;
            fc_latch <= next_fc_latch;
            page_latch <= next_page_latch;
            rf_latch <= next_rf_latch;
            jab_latch <= next_jab_latch;
            sd_latch <= next_sd_latch;
            lock_latch <= next_lock_latch;
        end
    end

    // ------------------------------------------------------------------
    // Interrupt source status and mask
    // ------------------------------------------------------------------
    logic [N-1:0] int_status;
    logic [N-1:0] int_mask;
    logic [N-1:0] int_events;
    logic [N-1:0] next_int_status;
    logic int_pending;

    // Rising faults and falling signal or lock are the events worth a wake-up.
    assign int_events = (rise & ~((N)'(1) << psm_pkg::IN_SIGNAL_DETECT)
                              & ~((N)'(1) << psm_pkg::IN_DESCRAMBLER_LOCK))
                        | (fall & (((N)'(1) << psm_pkg::IN_SIGNAL_DETECT)
                                   | ((N)'(1) << psm_pkg::IN_DESCRAMBLER_LOCK)));
    assign next_int_status = int_events
                             | (int_status & {N{!(rd_fire & sel_int_status)}});
    assign int_pending = |(int_status & int_mask);
    assign irq = int_pending;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= psm_pkg::EVENT_RESET;
        end else if (ce) begin
            int_status <= next_int_status;
        end
    end

    // ------------------------------------------------------------------
    // Read data assembly
    // ------------------------------------------------------------------
    logic [15:0] summary_word;
    logic [15:0] tenbt_word;
    logic [15:0] aneg_word;
    logic [15:0] basic_word;
    logic [15:0] read_word;

    // Bits outside 12 down to 5 belong to other logic and read as zero here.
    always_comb begin
        summary_word = psm_pkg::SUMMARY_RESET;
        summary_word[psm_pkg::SUM_POLARITY] = pol_latch;
        summary_word[psm_pkg::SUM_FALSE_CARRIER] = fc_latch;
        summary_word[psm_pkg::SUM_SIGNAL_DETECT] = sd_latch;
        summary_word[psm_pkg::SUM_DESCRAMBLER_LOCK] = lock_latch;
        summary_word[psm_pkg::SUM_PAGE_RECEIVED] = page_latch;
        summary_word[psm_pkg::SUM_INTERRUPT_PENDING] = int_pending;
        summary_word[psm_pkg::SUM_REMOTE_FAULT] = rf_latch;
        summary_word[psm_pkg::SUM_JABBER] = jab_latch;
        tenbt_word = 16'h0000;
        tenbt_word[psm_pkg::TENBT_POLARITY] = pol_latch;
        aneg_word = 16'h0000;
        aneg_word[psm_pkg::ANEG_PAGE_RECEIVED] = page_latch;
        basic_word = 16'h0000;
        basic_word[psm_pkg::BMS_REMOTE_FAULT] = rf_latch;
        basic_word[psm_pkg::BMS_JABBER] = jab_latch;
    end

    assign read_word = sel_summary ? summary_word :
                       sel_tenbt ? tenbt_word :
                       sel_aneg ? aneg_word :
                       sel_basic ? basic_word :
                       sel_int_status ? {9'h000, int_status} :
                       sel_int_mask ? {9'h000, int_mask} : 16'h0000;

    // The answer is captured at the address handshake, before the clear lands.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= psm_pkg::RESP_OKAY;
        end else if (ce) begin
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                s_axi_rdata <= {16'h0000, read_word};
                s_axi_rresp <= rd_mapped ? psm_pkg::RESP_OKAY : psm_pkg::RESP_DECERR;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic aw_held;
    logic w_held;
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic aw_fire;
    logic w_fire;
    logic wr_go;
    logic wr_mask;
    logic wr_ro;

    // Address and data are taken independently; the response waits for both.
    assign s_axi_awready = !aw_held && !bvalid_q && ce;
    assign s_axi_wready = !w_held && !bvalid_q && ce;
    assign s_axi_bvalid = bvalid_q && ce;
    assign aw_fire = s_axi_awvalid && s_axi_awready;
    assign w_fire = s_axi_wvalid && s_axi_wready;
    assign wr_go = aw_held && w_held && !bvalid_q;
    assign wr_mask = aw_addr == psm_pkg::ADDR_INTERRUPT_MASK;
    // Every mirror register is read-only, so a write there is refused.
    assign wr_ro = aw_addr == psm_pkg::ADDR_PHY_STATUS_SUMMARY
                   || aw_addr == psm_pkg::ADDR_TENBASE_T_STATUS_CONTROL
                   || aw_addr == psm_pkg::ADDR_FALSE_CARRIER_COUNTER
                   || aw_addr == psm_pkg::ADDR_AUTONEG_EXPANSION
                   || aw_addr == psm_pkg::ADDR_INTERRUPT_SOURCE_STATUS
                   || aw_addr == psm_pkg::ADDR_BASIC_MODE_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 10'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (w_fire) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    // Mask write and write response; only byte lane 0 carries mask bits.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_mask <= psm_pkg::MASK_RESET;
            bvalid_q <= 1'b0;
            s_axi_bresp <= psm_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                s_axi_bresp <= wr_mask ? psm_pkg::RESP_OKAY :
                               wr_ro ? psm_pkg::RESP_SLVERR : psm_pkg::RESP_DECERR;
                if (wr_mask && w_strb[0]) begin
                    int_mask <= w_data[N-1:0];
                end
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions and covers
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic sum_rd_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sum_rd_q <= 1'b0;
        end else begin
            sum_rd_q <= rd_fire && ce && sel_summary;
        end
    end

    pol_tenbt_clear_a: assert property (rd_fire && ce && sel_tenbt && !live[psm_pkg::IN_POLARITY]
        |=> !pol_latch) else $error("polarity not cleared by ten-base-T read");
    pol_summary_keep_a: assert property (pol_latch && rd_fire && ce && sel_summary
        |=> pol_latch) else $error("polarity lost on summary read");
    fc_hold_a: assert property (ce && fc_latch && !(rd_fire && sel_fc_counter)
        |=> fc_latch) else $error("false carrier latch dropped early");
    fc_set_a: assert property (ce && live[psm_pkg::IN_FALSE_CARRIER]
        |=> fc_latch) else $error("false carrier event missed");
    sd_latch_low_a: assert property (ce && !live[psm_pkg::IN_SIGNAL_DETECT]
        |=> !sd_latch) else $error("signal detect drop not latched");
    lock_follow_a: assert property (ce && rd_fire && sel_summary && live[psm_pkg::IN_DESCRAMBLER_LOCK]
        |=> lock_latch) else $error("lock not restored by summary read");
    page_keep_a: assert property (page_latch && ce && rd_fire && !sel_aneg
        |=> page_latch) else $error("page bit cleared by wrong read");
    rf_clear_a: assert property (ce && rd_fire && sel_basic && !live[psm_pkg::IN_REMOTE_FAULT]
        |=> !rf_latch) else $error("remote fault not cleared by basic status read");
    jab_dup_a: assert property (sum_rd_q
        |-> rvalid_q && s_axi_rdata[psm_pkg::SUM_JABBER] == $past(jab_latch)) else $error("jabber bit differs");
    int_read_a: assert property (ce && rd_fire && sel_int_status && !(|int_events)
        |=> !int_pending) else $error("pending interrupt survived its status read");
    irq_pending_a: assert property (sum_rd_q
        |-> s_axi_rdata[psm_pkg::SUM_INTERRUPT_PENDING] == $past(int_pending)) else $error("pending bit stale");

    sum_read_c: cover property (rd_fire && sel_summary && ce);
    clear_race_c: cover property (rd_fire && sel_fc_counter && live[psm_pkg::IN_FALSE_CARRIER] && ce);
    mask_write_c: cover property (wr_go && wr_mask && ce);
    irq_raise_c: cover property (!irq ##1 irq);

endmodule : psm_status_mirror

// ==== psm_status_mirror_tb.sv ====
// Self-checking bench for the status mirror bits and their clear-on-read links.
// Assumes psm_pkg and psm_status_mirror are compiled first; ready lines stay high.
`timescale 1ns/1ps
module psm_status_mirror_tb;
    logic aclk = 0, aresetn = 0, ce = 1, arvalid = 0, awvalid = 0, wvalid = 0;
    logic [9:0] araddr = 0, awaddr = 0;
    logic [31:0] wdata = 0, rdata, d;
    logic [1:0] rresp, bresp, r;
    logic arready, awready, wready, bvalid, rvalid, irq;
    logic [6:0] pin = 0;
    int fail_count = 0, samples_checked = 0;

    psm_status_mirror dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .polarity_inverted(pin[0]),
        .false_carrier(pin[1]), .signal_detect(pin[2]), .descrambler_lock(pin[3]), .page_received(pin[4]),
        .remote_fault(pin[5]), .jabber(pin[6]), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .irq(irq));

    // Free-running 100 MHz clock.
    initial forever #5 aclk = ~aclk;

    // Compares one value and counts it; a mismatch is reported at once.
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One read; arready and rvalid are sampled at the falling edge so no race with the rising one.
    task automatic rd(input logic [9:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
    endtask : rd

    // One write: address and data offered together, each released at the edge that takes it.
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        logic ta;
        logic tw;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awvalid && awready === 1'b1;
            tw = wvalid && wready === 1'b1;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while ((awvalid && !ta) || (wvalid && !tw));
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
    endtask : wr

    // Reads a register and compares the masked bits.
    task automatic rdc(input string n, input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        rd(a);
        chk(n, e, d & m);
    endtask : rdc

    // Looks at the interrupt line where it has settled, between two rising edges.
    task automatic chk_irq(input string n, input logic e);
        @(negedge aclk);
        chk(n, {31'h0, e}, {31'h0, irq});
        @(posedge aclk);
    endtask : chk_irq

    // Pin held long enough to pass the synchroniser, then released.
    task automatic pulse(input int i);
        pin[i] <= 1'b1;
        repeat (6) @(posedge aclk);
        pin[i] <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask : pulse

    // Latch-high bits: set by the event, kept over summary reads, cleared by their own register.
    task automatic t_latch_high();
        int pi[5] = '{0, 1, 4, 5, 6};
        int sb[5] = '{12, 11, 8, 6, 5};
        logic [31:0] sm[5] = '{32'h10, 32'h0, 32'h2, 32'h10, 32'h2};
        logic [9:0] ca[5] = '{psm_pkg::ADDR_TENBASE_T_STATUS_CONTROL, psm_pkg::ADDR_FALSE_CARRIER_COUNTER,
            psm_pkg::ADDR_AUTONEG_EXPANSION, psm_pkg::ADDR_BASIC_MODE_STATUS, psm_pkg::ADDR_BASIC_MODE_STATUS};
        for (int k = 0; k < 5; k++) begin
            pulse(pi[k]);
            rdc("bit set", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 1 << sb[k], 1 << sb[k]);
            rdc("bit kept", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 1 << sb[k], 1 << sb[k]);
            rdc("source bit", ca[k], 32'hFFFF, sm[k]);
            rdc("bit cleared", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 1 << sb[k], 32'h0);
        end
    endtask : t_latch_high

    // Latch-low bits: a dip is held at 0 until the summary is read, then the live level shows.
    task automatic t_latch_low();
        pin[3:2] <= 2'h3;
        repeat (6) @(posedge aclk);
        rd(psm_pkg::ADDR_PHY_STATUS_SUMMARY);
        rdc("live", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'h600, 32'h600);
        pin[3:2] <= 2'h0;
        repeat (6) @(posedge aclk);
        pin[3:2] <= 2'h3;
        repeat (6) @(posedge aclk);
        rdc("held low", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'h600, 32'h0);
        rdc("rearmed", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'h600, 32'h600);
    endtask : t_latch_low

    // Interrupt: masked event stays quiet, unmasked one raises irq and bit 7 until the events are read.
    task automatic t_irq();
        rd(psm_pkg::ADDR_INTERRUPT_SOURCE_STATUS);
        wr(psm_pkg::ADDR_INTERRUPT_MASK, 32'h20);
        chk("mask resp", {30'h0, psm_pkg::RESP_OKAY}, {30'h0, r});
        pulse(6);
        chk_irq("irq masked", 1'b0);
        pulse(5);
        chk_irq("irq", 1'b1);
        rdc("pending", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'h80, 32'h80);
        rdc("events", psm_pkg::ADDR_INTERRUPT_SOURCE_STATUS, 32'h60, 32'h60);
        chk_irq("irq cleared", 1'b0);
        rdc("pending cleared", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'h80, 32'h0);
    endtask : t_irq

    // Reset held four cycles; with a fault first, the mid-run reset must wipe it, the mask and irq.
    task automatic t_reset(input logic fault);
        if (fault) begin
            pulse(5);
            rdc("fault before reset", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'h40, 32'h40);
        end
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdc("reset", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'hFFFF, 32'h0);
        rdc("mask reset", psm_pkg::ADDR_INTERRUPT_MASK, 32'h7F, 32'h0);
        chk_irq("irq after reset", 1'b0);
    endtask : t_reset

    // Enable low: the bus refuses requests and an event on a pin is never seen.
    task automatic t_freeze();
        ce <= 1'b0;
        @(negedge aclk);
        chk("ready while frozen", 32'h0, {31'h0, arready});
        @(posedge aclk);
        pulse(1);
        ce <= 1'b1;
        rdc("frozen event", psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'h800, 32'h0);
    endtask : t_freeze

    // Refusals: an unmapped read and a write to a read-only mirror.
    task automatic t_refuse();
        rdc("unmapped", 10'h3FC, 32'hFFFFFFFF, 32'h0);
        chk("unmapped resp", {30'h0, psm_pkg::RESP_DECERR}, {30'h0, r});
        wr(psm_pkg::ADDR_PHY_STATUS_SUMMARY, 32'hFFFF);
        chk("ro resp", {30'h0, psm_pkg::RESP_SLVERR}, {30'h0, r});
    endtask : t_refuse

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    // Watchdog: the whole sequence needs well under a thousand cycles.
    initial begin
        #100000;
        fail_count++;
        test_done();
    end

    // Main sequence: reset, reset values, scenarios, bus refusals.
    initial begin
        t_reset(1'b0);
        t_latch_high();
        t_latch_low();
        t_irq();
        t_reset(1'b1);
        t_freeze();
        t_refuse();
        test_done();
    end
endmodule : psm_status_mirror_tb
